// file: srrc_params.svh
// constants for the stand-by RAM retention control block
// assumes inclusion by bare name from the package and design modules
`ifndef SRRC_PARAMS_SVH
`define SRRC_PARAMS_SVH
// reset value of the retained RAM interface enable bit
`define SRRC_ENABLE_RST 1'b0
// supply select encoding: 1 selects the stand-by supply
`define SRRC_SEL_STANDBY 1'b1
`define SRRC_SEL_MAIN 1'b0
// retained RAM size in bytes and address width (16 Kbytes)
`define SRRC_RAM_BYTES 16384
`define SRRC_ADDR_W 14
`define SRRC_DATA_W 16
// mode table encodings
`define SRRC_MODE_RUN 2'h0
`define SRRC_MODE_IDLE 2'h1
`define SRRC_MODE_PWRDN 2'h2
`define SRRC_MODE_STBY 2'h3
`endif

// file: srrc_pkg.sv
// types for the stand-by RAM retention control block
// assumes srrc_params.svh sits in the include path
`include "srrc_params.svh"
package srrc_pkg;
   // power mode of the device as seen by this block
   typedef enum logic [1:0] {
      SRRC_RUN = 2'h0,
      SRRC_IDLE = 2'h1,
      SRRC_PWRDN = 2'h2,
      SRRC_STBY = 2'h3
   } srrc_mode_e;
   // supply sequencing states
   typedef enum logic [1:0] {
      SRRC_SQ_RESET = 2'h0,
      SRRC_SQ_MAIN_FROZEN = 2'h1,
      SRRC_SQ_ACTIVE = 2'h2
   } srrc_seq_e;
endpackage : srrc_pkg

// file: srrc_ram_gate.sv
// extra gating stage in front of the retained RAM
// assumes strobes arrive registered on core_clk
`include "srrc_params.svh"
module srrc_ram_gate (
   input wire logic core_clk,
   input wire logic reset_n,
   srrc_ram_if.gate ramIf,
   output logic ramRd,
   output logic ramWr,
   output logic [`SRRC_ADDR_W-1:0] ramAddr,
   output logic [`SRRC_DATA_W-1:0] ramWdata
);
   // strobes are forced inactive while frozen; a collapsing core cannot
   // leak a half-level write strobe through this registered stage
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ramRd <= 1'b0;
         ramWr <= 1'b0;
      end else begin
         ramRd <= ramIf.rdStrobe & ~ramIf.freeze;
         ramWr <= ramIf.wrStrobe & ~ramIf.freeze;
      end
   end
   // address and data held while frozen so the bus looks quiet
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ramAddr <= '0;
         ramWdata <= '0;
      end else if (!ramIf.freeze) begin
         ramAddr <= ramIf.addr;
         ramWdata <= ramIf.wrData;
      end
   end
   // no strobe may leave while the freeze is held
   AST_GATE_BLOCKS: assert property (@(posedge core_clk) disable iff
      (!reset_n) $past(ramIf.freeze) |-> !ramWr && !ramRd)
      else $error("strobe passed a frozen gate");
endmodule : srrc_ram_gate

// file: srrc_ram_if.sv
// interface carrying core-side RAM strobes to the guarded RAM port
// assumes one clock domain, core_clk
`include "srrc_params.svh"
interface srrc_ram_if;
   logic rdStrobe; // core read request
   logic wrStrobe; // core write request
   logic [`SRRC_ADDR_W-1:0] addr; // word address
   logic [`SRRC_DATA_W-1:0] wrData; // write data
   logic freeze; // freeze command from the sequencer
   modport core (output rdStrobe, output wrStrobe, output addr,
      output wrData, output freeze);
   modport gate (input rdStrobe, input wrStrobe, input addr,
      input wrData, input freeze);
endinterface : srrc_ram_if

// file: srrc_retention_ctrl.sv
// stand-by RAM retention control: freeze, supply select, RTC keep-alive
// assumes comparator levels and pins are asynchronous to core_clk
`include "srrc_params.svh"
module srrc_retention_ctrl (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic externalResetInput_n, // reset pin, active low
   input wire logic lowVoltageDetector_n, // low until core above ~1.0V
   input wire logic coreAboveStandbyRef, // comparator: core over reference
   input wire logic coreDipDetected, // comparator: shallow 0.3-0.45V dip
   input wire logic standbySupplyPin, // pin level, strap during reset
   input wire logic enableWrite, // software write strobe
   input wire logic enableWdata, // value of the enable bit written
   input wire logic idleReq, // idle instruction executed
   input wire logic pwrdnReq, // power-down instruction executed
   input wire logic wakeReq, // interrupt wake
   input wire logic rtcUse32k, // rtc referenced to the 32 kHz oscillator
   input wire logic osc32kTick, // 32 kHz oscillator tick, asynchronous
   input wire logic coreRd,
   input wire logic coreWr,
   input wire logic [`SRRC_ADDR_W-1:0] coreAddr,
   input wire logic [`SRRC_DATA_W-1:0] coreWdata,
   output logic ramFreeze,
   output logic supplySelStandby,
   output logic retainedRamInterfaceEnable,
   output logic externalAccessSelect,
   output logic rtcRun,
   output logic cpuRun,
   output logic periphRun,
   output logic mainOscRun,
   output logic [1:0] modeState,
   output logic ramRd,
   output logic ramWr,
   output logic [`SRRC_ADDR_W-1:0] ramAddr,
   output logic [`SRRC_DATA_W-1:0] ramWdata
);
   logic rstPinSync; // synchronised reset pin, high = released
   logic lvdSync; // synchronised detector, high = core above ~1.0V
   logic aboveRefSync; // synchronised reference comparator
   logic dipSync; // synchronised shallow dip comparator
   logic strapSync; // synchronised stand-by pin level
   logic tickSync; // synchronised 32 kHz tick
   logic tickPrev_r; // previous tick for edge detection
   logic internalReset; // combined internal reset request
   logic lowSupply; // qualified low core supply
   logic enable_r; // retained RAM interface enable bit
   logic strapTaken_r; // strap captured once per reset release
   srrc_pkg::srrc_seq_e seq_r, seq_nxt; // supply sequencing state
   srrc_pkg::srrc_mode_e mode_r; // power mode state
   srrc_ram_if ramIf ();

   // every asynchronous level passes two flops before use, style
   srrc_sync2 uSyncRst (.core_clk(core_clk), .reset_n(reset_n),
      .asyncIn(externalResetInput_n), .syncOut(rstPinSync));
   srrc_sync2 uSyncLvd (.core_clk(core_clk), .reset_n(reset_n),
      .asyncIn(lowVoltageDetector_n), .syncOut(lvdSync));
   srrc_sync2 uSyncRef (.core_clk(core_clk), .reset_n(reset_n),
      .asyncIn(coreAboveStandbyRef), .syncOut(aboveRefSync));
   srrc_sync2 uSyncDip (.core_clk(core_clk), .reset_n(reset_n),
      .asyncIn(coreDipDetected), .syncOut(dipSync));
   srrc_sync2 uSyncStrap (.core_clk(core_clk), .reset_n(reset_n),
      .asyncIn(standbySupplyPin), .syncOut(strapSync));
   srrc_sync2 uSyncTick (.core_clk(core_clk), .reset_n(reset_n),
      .asyncIn(osc32kTick), .syncOut(tickSync));

   // internal reset: pin low, or detector still holding below ~1.0V;
   // the pin alone is not trusted; the detector still holds reset if the pin floats high
   assign internalReset = !rstPinSync || !lvdSync;

   // a shallow dip with the enable set is not a stand-by event;
   // with the enable clear any fall below the reference counts
   assign lowSupply = !aboveRefSync && !(enable_r && dipSync);

   // enable bit: cleared by any reset, set only by software
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         enable_r <= `SRRC_ENABLE_RST;
      end else if (internalReset) begin
         enable_r <= `SRRC_ENABLE_RST;
      end else if (enableWrite) begin
         enable_r <= enableWdata;
      end
   end

   // sequencing: reset -> main supply but frozen -> active
   always_comb begin
      seq_nxt = seq_r;
      case (seq_r)
         srrc_pkg::SRRC_SQ_RESET: begin
            if (!internalReset) begin
               seq_nxt = srrc_pkg::SRRC_SQ_MAIN_FROZEN;
            end
         end
         srrc_pkg::SRRC_SQ_MAIN_FROZEN: begin
            if (internalReset) begin
               seq_nxt = srrc_pkg::SRRC_SQ_RESET;
            end else if (enable_r && !lowSupply) begin
               seq_nxt = srrc_pkg::SRRC_SQ_ACTIVE;
            end
         end
         srrc_pkg::SRRC_SQ_ACTIVE: begin
            if (internalReset) begin
               seq_nxt = srrc_pkg::SRRC_SQ_RESET;
            end else if (!enable_r || lowSupply) begin
               seq_nxt = srrc_pkg::SRRC_SQ_MAIN_FROZEN;
            end
         end
         default: begin
            seq_nxt = srrc_pkg::SRRC_SQ_RESET;
         end
      endcase
   end

   // state register for the supply sequence
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         seq_r <= srrc_pkg::SRRC_SQ_RESET;
      end else begin
         seq_r <= seq_nxt;
      end
   end

   // freeze is combinational toward the gate so a clear acts at once;
   // the gate then registers it, costing one cycle at the RAM pins
   assign ramIf.freeze = internalReset || !enable_r || lowSupply
      || (seq_r != srrc_pkg::SRRC_SQ_ACTIVE);
   assign ramIf.rdStrobe = coreRd;
   assign ramIf.wrStrobe = coreWr;
   assign ramIf.addr = coreAddr;
   assign ramIf.wrData = coreWdata;

   // registered status outputs for freeze and supply select
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ramFreeze <= 1'b1;
         supplySelStandby <= `SRRC_SEL_STANDBY;
         retainedRamInterfaceEnable <= `SRRC_ENABLE_RST;
      end else begin
         ramFreeze <= ramIf.freeze;
         supplySelStandby <= internalReset ? `SRRC_SEL_STANDBY
            : `SRRC_SEL_MAIN;
         retainedRamInterfaceEnable <= enable_r;
      end
   end

   // strap: the stand-by pin is caught once, at the reset release
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         strapTaken_r <= 1'b0;
         externalAccessSelect <= 1'b0;
      end else if (internalReset) begin
         strapTaken_r <= 1'b0;
      end else if (!strapTaken_r) begin
         strapTaken_r <= 1'b1;
         externalAccessSelect <= !strapSync;
      end
   end

   // power mode: reset means stand-by, instructions pick idle/power-down
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_r <= srrc_pkg::SRRC_STBY;
      end else if (internalReset) begin
         mode_r <= srrc_pkg::SRRC_STBY;
      end else if (wakeReq || mode_r == srrc_pkg::SRRC_STBY) begin
         mode_r <= srrc_pkg::SRRC_RUN;
      end else if (pwrdnReq) begin
         mode_r <= srrc_pkg::SRRC_PWRDN;
      end else if (idleReq) begin
         mode_r <= srrc_pkg::SRRC_IDLE;
      end
   end

   // tick edge history; the rtc enable does not read it
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tickPrev_r <= 1'b0;
      end else begin
         tickPrev_r <= tickSync;
      end
   end

   // domain enables per the summary table; in stand-by only the rtc
   // on the 32 kHz oscillator keeps running, main domain is off
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cpuRun <= 1'b0;
         periphRun <= 1'b0;
         mainOscRun <= 1'b0;
         rtcRun <= 1'b0;
         modeState <= `SRRC_MODE_STBY;
      end else begin
         cpuRun <= (mode_r == srrc_pkg::SRRC_RUN);
         periphRun <= (mode_r == srrc_pkg::SRRC_RUN)
            || (mode_r == srrc_pkg::SRRC_IDLE);
         mainOscRun <= (mode_r != srrc_pkg::SRRC_STBY)
            && !(mode_r == srrc_pkg::SRRC_PWRDN && rtcUse32k);
         rtcRun <= (mode_r == srrc_pkg::SRRC_STBY) ? rtcUse32k
            : 1'b1;
         modeState <= mode_r;
      end
   end

   // extra gating stage between core strobes and the RAM
   srrc_ram_gate uGate (.core_clk(core_clk), .reset_n(reset_n),
      .ramIf(ramIf), .ramRd(ramRd), .ramWr(ramWr),
      .ramAddr(ramAddr), .ramWdata(ramWdata));

   // steps of a stand-by exit: reset, then main frozen, then active
   sequence seqResetHeld;
      internalReset [*2];
   endsequence
   sequence seqReleased;
      !internalReset;
   endsequence

   AST_RESET_FREEZES: assert property (@(posedge core_clk)
      disable iff (!reset_n) internalReset |=> ramFreeze)
      else $error("reset did not freeze the RAM");
   AST_CLEAR_FREEZES: assert property (@(posedge core_clk)
      disable iff (!reset_n) !enable_r |-> ramIf.freeze)
      else $error("clear enable left RAM unfrozen");
   AST_RESET_STANDBY_SUPPLY: assert property (@(posedge core_clk)
      disable iff (!reset_n) internalReset |=> supplySelStandby)
      else $error("reset left RAM on main supply");
   AST_ENABLE_CLEARED: assert property (@(posedge core_clk)
      disable iff (!reset_n) internalReset |=> !enable_r)
      else $error("enable survived reset");
   AST_LOW_SUPPLY_FREEZE: assert property (@(posedge core_clk)
      disable iff (!reset_n) (!aboveRefSync && !enable_r) |=> ramFreeze)
      else $error("low supply did not freeze");
   AST_DIP_IGNORED: assert property (@(posedge core_clk)
      disable iff (!reset_n) (enable_r && dipSync && !internalReset
      && seq_r == srrc_pkg::SRRC_SQ_ACTIVE) |-> !ramIf.freeze)
      else $error("shallow dip froze the RAM");
   AST_EXIT_MAIN_SUPPLY: assert property (@(posedge core_clk)
      disable iff (!reset_n) seqResetHeld ##1 seqReleased |=>
      !supplySelStandby && ramFreeze)
      else $error("exit did not move frozen RAM to main supply");
   // release takes two steps: the sequencer moves to active, then the
   // freeze falls; a reset or clear in between must cancel the check
   sequence seqReadyToRelease;
      seq_r == srrc_pkg::SRRC_SQ_MAIN_FROZEN && enable_r && !lowSupply
         && !internalReset;
   endsequence
   sequence seqStillReady;
      enable_r && !lowSupply && !internalReset;
   endsequence
   AST_ENABLE_RELEASES: assert property (@(posedge core_clk)
      disable iff (!reset_n) seqReadyToRelease ##1 seqStillReady |=>
      !ramFreeze)
      else $error("enable did not release the freeze");
   AST_RTC_STANDBY: assert property (@(posedge core_clk)
      disable iff (!reset_n) (mode_r == srrc_pkg::SRRC_STBY && !rtcUse32k)
      |=> !rtcRun)
      else $error("rtc ran in stand-by without 32k");
   AST_STANDBY_DOMAINS: assert property (@(posedge core_clk)
      disable iff (!reset_n) mode_r == srrc_pkg::SRRC_STBY |=>
      !cpuRun && !periphRun && !mainOscRun)
      else $error("main domain alive in stand-by");

   // a rail below the reference with no shallow-dip flag is a real
   // low supply, whatever the enable bit holds
   AST_LOW_SUPPLY_HOLDS: assert property (@(posedge core_clk)
      disable iff (!reset_n) (!aboveRefSync && !dipSync) |=> ramFreeze)
      else $error("deep sag left the RAM unfrozen");
   // once reset is gone the RAM must sit on the main rail
   AST_MAIN_SUPPLY_RUN: assert property (@(posedge core_clk)
      disable iff (!reset_n) !internalReset |=> !supplySelStandby)
      else $error("RAM left on stand-by supply after reset");
   // strap is caught from the pin level seen at the reset release
   AST_STRAP_CAPTURE: assert property (@(posedge core_clk)
      disable iff (!reset_n) internalReset ##1 seqReleased |=>
      externalAccessSelect == !$past(strapSync))
      else $error("access strap not taken at reset release");
   // the device leaves stand-by into run one cycle after release
   AST_RUN_AFTER_EXIT: assert property (@(posedge core_clk)
      disable iff (!reset_n) (mode_r == srrc_pkg::SRRC_STBY
      && !internalReset) |=> mode_r == srrc_pkg::SRRC_RUN)
      else $error("stand-by did not end after reset release");
   // idle stops only the CPU; peripherals and main oscillator run
   AST_IDLE_DOMAINS: assert property (@(posedge core_clk)
      disable iff (!reset_n) mode_r == srrc_pkg::SRRC_IDLE |=>
      !cpuRun && periphRun && mainOscRun)
      else $error("idle domain enables wrong");
   // power-down stops the CPU and the peripherals alike
   AST_PWRDN_DOMAINS: assert property (@(posedge core_clk)
      disable iff (!reset_n) mode_r == srrc_pkg::SRRC_PWRDN |=>
      !cpuRun && !periphRun)
      else $error("power-down left a domain running");
endmodule : srrc_retention_ctrl

// file: srrc_supply_model.sv
// partner model: external reset supervisor, supply rails and comparators
// assumes the bench drives its requests by non-blocking assignment
module srrc_supply_model #(
   parameter int HOLD_CYCLES = 6 // supply settle time before reset release
) (
   input wire logic core_clk,
   input wire logic mainOn, // main supply switched on
   input wire logic dipReq, // shallow core dip, enable bit keeps RAM open
   input wire logic sagReq, // deep core sag below the stand-by reference
   input wire logic strapLow, // stand-by pin tied low as access strap
   input wire logic earlyRelease, // misbehaving supervisor lets pin go high
   output logic externalResetInput_n,
   output logic lowVoltageDetector_n,
   output logic coreAboveStandbyRef,
   output logic coreDipDetected,
   output logic standbySupplyPin
);
   timeunit 1ns;
   timeprecision 1ps;
   int stableCnt; // cycles since the main supply came on
   // ramp counter, cleared at once when the supply collapses
   always @(posedge core_clk or negedge mainOn) begin
      if (!mainOn) begin
         stableCnt <= 0;
      end else if (stableCnt < HOLD_CYCLES) begin
         stableCnt <= stableCnt + 1;
      end
   end
   // detector rises early in the ramp, before the rail is settled
   assign lowVoltageDetector_n = mainOn && stableCnt >= 2;
   // comparator levels only, never derived by the block itself
   assign coreAboveStandbyRef = mainOn && stableCnt >= 3 && !dipReq &&
      !sagReq;
   assign coreDipDetected = mainOn && dipReq;
   // reset pin held low, glitch free, until the supply is stable, unless earlyRelease forces it high
   assign externalResetInput_n = earlyRelease ||
      stableCnt >= HOLD_CYCLES;
   // strap level seen on the shared supply pin
   assign standbySupplyPin = !strapLow;
endmodule : srrc_supply_model

// file: srrc_sync2.sv
// two flop synchroniser for pin and comparator levels
// assumes an asynchronous, active low reset on core_clk
module srrc_sync2 (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic asyncIn,
   output logic syncOut
);
   logic stage1_r; // metastable stage, read only by the second flop
   // plain double flop; reset to a constant, never to a port value
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1_r <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         stage1_r <= asyncIn;
         syncOut <= stage1_r;
      end
   end
endmodule : srrc_sync2

// file: srrc_testbench.sv
// self-checking bench for the stand-by RAM retention control
// assumes srrc_params.svh is on the include path; one 25 MHz clock
`include "srrc_params.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, reset_n = 1'b0;
   logic mainOn = 1'b0, dipReq = 1'b0, sagReq = 1'b0;
   logic strapLow = 1'b1, earlyRelease = 1'b0;
   logic extRst_n, lvd_n, aboveRef, dipDet, stbyPin;
   logic enableWrite = 1'b0, enableWdata = 1'b0;
   logic idleReq = 1'b0, pwrdnReq = 1'b0, wakeReq = 1'b0;
   logic rtcUse32k = 1'b0, osc32kTick = 1'b0;
   logic coreRd = 1'b0, coreWr = 1'b0;
   logic [`SRRC_ADDR_W-1:0] coreAddr = '0, ramAddr;
   logic [`SRRC_DATA_W-1:0] coreWdata = '0, ramWdata;
   logic ramFreeze, supplySelStandby, enBit, accSel, rtcRun;
   logic cpuRun, periphRun, mainOscRun, ramRd, ramWr;
   logic [1:0] modeState;
   int num_errors = 0, compares = 0;
   // 40 ns period
   always #20 core_clk = ~core_clk;
   // slow tick, unrelated to the core clock edges
   always #15259 osc32kTick = ~osc32kTick;
   srrc_supply_model #(.HOLD_CYCLES(6)) supply_u (.core_clk(core_clk),
      .mainOn(mainOn), .dipReq(dipReq), .sagReq(sagReq),
      .strapLow(strapLow), .earlyRelease(earlyRelease),
      .externalResetInput_n(extRst_n), .lowVoltageDetector_n(lvd_n),
      .coreAboveStandbyRef(aboveRef), .coreDipDetected(dipDet),
      .standbySupplyPin(stbyPin));
   srrc_retention_ctrl dut_u (.core_clk(core_clk), .reset_n(reset_n),
      .externalResetInput_n(extRst_n), .lowVoltageDetector_n(lvd_n),
      .coreAboveStandbyRef(aboveRef), .coreDipDetected(dipDet),
      .standbySupplyPin(stbyPin), .enableWrite(enableWrite),
      .enableWdata(enableWdata), .idleReq(idleReq), .pwrdnReq(pwrdnReq),
      .wakeReq(wakeReq), .rtcUse32k(rtcUse32k), .osc32kTick(osc32kTick),
      .coreRd(coreRd), .coreWr(coreWr), .coreAddr(coreAddr),
      .coreWdata(coreWdata), .ramFreeze(ramFreeze),
      .supplySelStandby(supplySelStandby),
      .retainedRamInterfaceEnable(enBit), .externalAccessSelect(accSel),
      .rtcRun(rtcRun), .cpuRun(cpuRun), .periphRun(periphRun),
      .mainOscRun(mainOscRun), .modeState(modeState), .ramRd(ramRd),
      .ramWr(ramWr), .ramAddr(ramAddr), .ramWdata(ramWdata));
   // verdict and end of run, the only exit
   task automatic print_verdict();
      if (num_errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   // one comparison, four-state exact
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // bounded wait on a status output; a timeout ends the run
   task automatic wait_until(input int sel, input logic [1:0] val);
      logic [1:0] cur;
      for (int i = 0; i < 16; i++) begin
         @(posedge core_clk);
         #1;
         case (sel)
            0: cur = {1'b0, ramFreeze};
            1: cur = {1'b0, supplySelStandby};
            default: cur = modeState;
         endcase
         if (cur === val) return;
      end
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, cur, val);
      print_verdict();
   endtask : wait_until
   // software write of the enable bit, one cycle strobe
   task automatic set_enable(input logic v);
      @(posedge core_clk);
      enableWrite <= 1'b1;
      enableWdata <= v;
      @(posedge core_clk);
      enableWrite <= 1'b0;
   endtask : set_enable
   // one core access; pass says whether it must reach the RAM port
   task automatic core_access(input logic wr, input logic [13:0] a,
      input logic [15:0] d, input logic pass);
      @(posedge core_clk);
      coreWr <= wr;
      coreRd <= !wr;
      coreAddr <= a;
      coreWdata <= d;
      @(posedge core_clk);
      coreWr <= 1'b0;
      coreRd <= 1'b0;
      #1;
      chk(wr ? ramWr : ramRd, pass);
      if (pass) begin
         chk(ramAddr, a);
         if (wr) chk(ramWdata, d);
      end
   endtask : core_access
   // one-cycle pulse on a mode request
   task automatic pulse(input int which);
      @(posedge core_clk);
      idleReq <= which == 0;
      pwrdnReq <= which == 1;
      wakeReq <= which == 2;
      @(posedge core_clk);
      {idleReq, pwrdnReq, wakeReq} <= 3'h0;
   endtask : pulse
   // pin released early while the supply is off: detector still holds
   task automatic sc_detector_hold();
      earlyRelease <= 1'b1;
      repeat (8) @(posedge core_clk);
      #1;
      chk(supplySelStandby, 1'b1);
      chk(modeState, 2'h3);
      earlyRelease <= 1'b0;
   endtask : sc_detector_hold
   // power-on exit: main supply back, RAM still frozen, strap taken
   task automatic sc_power_on();
      @(posedge core_clk);
      mainOn <= 1'b1;
      wait_until(1, 2'h0);
      chk(ramFreeze, 1'b1);
      chk(enBit, 1'b0);
      chk(accSel, 1'b1);
      core_access(1'b1, 14'h0011, 16'h1234, 1'b0);
      strapLow <= 1'b0;
      set_enable(1'b1);
      wait_until(0, 2'h0);
      chk(enBit, 1'b1);
      core_access(1'b1, 14'h3fff, 16'ha5c3, 1'b1);
      core_access(1'b0, 14'h2a55, 16'h0000, 1'b1);
   endtask : sc_power_on
   // shallow dip ignored, deep sag freezes even with the enable bit set
   task automatic sc_supply_dips();
      dipReq <= 1'b1;
      repeat (5) @(posedge core_clk);
      #1;
      chk(ramFreeze, 1'b0);
      core_access(1'b1, 14'h0001, 16'hfffe, 1'b1);
      dipReq <= 1'b0;
      sagReq <= 1'b1;
      wait_until(0, 2'h1);
      core_access(1'b1, 14'h0002, 16'h5aa5, 1'b0);
      chk(enBit, 1'b1);
      sagReq <= 1'b0;
      wait_until(0, 2'h0);
   endtask : sc_supply_dips
   // clearing the enable bit blocks the very next write
   task automatic sc_clear_enable();
      set_enable(1'b0);
      core_access(1'b1, 14'h0100, 16'h00ff, 1'b0);
      chk(ramFreeze, 1'b1);
      set_enable(1'b1);
      wait_until(0, 2'h0);
   endtask : sc_clear_enable
   // idle and power-down states of the mode table
   task automatic sc_modes();
      pulse(0);
      wait_until(2, 2'h1);
      chk({cpuRun, periphRun, mainOscRun}, 3'h3);
      pulse(2);
      wait_until(2, 2'h0);
      chk(cpuRun, 1'b1);
      pulse(1);
      wait_until(2, 2'h2);
      chk({cpuRun, periphRun}, 2'h0);
      pulse(2);
      wait_until(2, 2'h0);
   endtask : sc_modes
   // supply off with the clock on the 32 kHz reference, then power-on
   task automatic sc_standby();
      @(posedge core_clk);
      rtcUse32k <= 1'b1;
      mainOn <= 1'b0;
      wait_until(1, 2'h1);
      wait_until(0, 2'h1);
      chk(modeState, 2'h3);
      chk({cpuRun, periphRun, mainOscRun}, 3'h0);
      repeat (3) @(posedge core_clk);
      #1;
      chk(rtcRun, 1'b1);
      @(posedge core_clk);
      rtcUse32k <= 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      chk(rtcRun, 1'b0);
      mainOn <= 1'b1;
      wait_until(1, 2'h0);
      chk({ramFreeze, enBit}, 2'h2);
      chk(accSel, 1'b0);
   endtask : sc_standby
   // hang guard
   initial begin
      repeat (5000) @(posedge core_clk);
      num_errors++;
      print_verdict();
   end
   // main sequence
   initial begin
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      #1;
      chk(supplySelStandby, 1'b1);
      sc_detector_hold();
      sc_power_on();
      sc_supply_dips();
      sc_clear_enable();
      sc_modes();
      sc_standby();
      print_verdict();
   end
endmodule : testbench
